// file: verilog/clock_divider_params.svh
// Offsets, field positions, reset values and counts for the clock divider.
// Assumes a byte-addressed APB register window with 32-bit words.
`ifndef CLOCK_DIVIDER_PARAMS_SVH
`define CLOCK_DIVIDER_PARAMS_SVH
// Register byte offsets
`define OFS_RUN_CFG   8'h00
`define OFS_RUN_EXT   8'h04
`define OFS_DSLP_CFG  8'h08
`define OFS_GATE      8'h0c
`define OFS_STATUS    8'h10
// Field positions
`define POS_OSC_OFF   0
`define POS_OSC_SEL   4
`define POS_CRYSTAL_SELECT      6
`define POS_SKIP      11
`define POS_PLL_PD    13
`define POS_DIV_EN    22
`define POS_DIV       23
`define POS_USE_EXT   31
// Writable bits; the rest read as zero
`define MASK_RUN_CFG  32'h07c02ff1
`define MASK_RUN_EXT  32'h9f802870
`define MASK_DSLP_CFG 32'h1f800070
// Reset values: run registers on internal oscillator, PLL skipped and off, divider code 0xf
`define RST_RUN_CFG   32'h07802811
`define RST_RUN_EXT   32'h07802810
`define RST_DSLP_CFG  32'h00000000
`define RST_GATE      32'h00000000
// Source select codes
`define SRC_MAIN      3'h0
`define SRC_INT       3'h1
`define SRC_INT4      3'h2
`define SRC_SLOW      3'h3
`define SRC_RTC       3'h7
// Rates and counts
`define VCO_MHZ       400
`define ADC_MHZ       16
`define ADC_DIV       (`VCO_MHZ / `ADC_MHZ)
`define INT_PRE_DIV   4
`define N_PERIPH      8
`endif

// file: verilog/clock_divider_pkg.sv
// Types shared by the clock divider and its environment.
// Assumes the constants header is compiled alongside.
package clock_divider_pkg;
    // APB request from the master
    typedef struct packed {
        logic        psel;
        logic        penable;
        logic        pwrite;
        logic [7:0]  paddr;
        logic [31:0] pwdata;
    } apb_req_t;
    // APB answer to the master
    typedef struct packed {
        logic        pready;
        logic        pslverr;
        logic [31:0] prdata;
    } apb_rsp_t;
    // Effective clock configuration
    typedef struct packed {
        logic       use_pll;
        logic [2:0] src;
        logic [6:0] divisor;
    } clk_cfg_t;
endpackage

// file: verilog/system_clock_source_divider.sv
// System clock source selection and division, ADC clock, peripheral gates.
// Every oscillator arrives as a one-cycle tick synchronous to mclk_in,
// so every derived clock leaves as a one-cycle enable pulse.
`timescale 1ns/1ps
`include "clock_divider_params.svh"

// Overview of operation
// - Reset leaves the system clock on the internal oscillator.
// - PLL skipped: select 0 main, 1 internal, 2 internal/4, 3 slow.
// - Real-time oscillator only with PLL skipped and wide select 7.
// - PLL, fed by main oscillator, used when skip 0 and select 0.
// - Override bit in second register makes its fields govern.
// - With override, each second-register field replaces the first.
// - Divisor is divider code plus one, on PLL path or enabled oscillator path from code 1.
// - PLL path halves the VCO before the divider.
// - Divider code resets to 0xf with the divider disabled, so divide by one.
// - Oscillator path codes 0 and 1 both divide by two.
// - Divider disabled without PLL passes the source undivided.
// - Wide divider field has two more bits, up to divide by 64.
// - ADC clock derived at 16 MHz regardless of system divider.
// - Each peripheral clock has its own individual gate.
// - In deep sleep the deep-sleep register picks source and divider.
module system_clock_source_divider (
    // Clock and reset
    input  wire logic                         mclk_in,
    input  wire logic                         rstn_in,
    // APB slave
    input  wire clock_divider_pkg::apb_req_t  apb_req_in,
    output      clock_divider_pkg::apb_rsp_t  apb_rsp_out,
    // Oscillator ticks
    input  wire logic                         internal_osc_tick_in,
    input  wire logic                         main_osc_tick_in,
    input  wire logic                         slow_osc_tick_in,
    input  wire logic                         rtc_osc_tick_in,
    input  wire logic                         pll_vco_tick_in,
    // Power mode
    input  wire logic                         deep_sleep_in,
    // Oscillator and PLL controls
    output      logic                         main_osc_enable_out,
    output      logic                         pll_power_on_out,
    output      logic [4:0]                   crystal_select_out,
    // Derived clock enables
    output      logic                         system_clock_en_out,
    output      logic                         adc_clock_en_out,
    output      logic [`N_PERIPH-1:0]         periph_clock_en_out
);
    import clock_divider_pkg::*;

    ////////////////////////////////////////////////////////////////////
    // Registers
    logic [31:0] run_cfg_q;
    logic [31:0] run_ext_q;
    logic [31:0] dslp_cfg_q;
    logic [31:0] gate_q;
    logic [31:0] rdata_d;
    logic [31:0] prdata_q;
    logic        hit;
    logic        setup;
    logic        access;

    // Effective configuration
    clk_cfg_t    run_cfg;
    clk_cfg_t    dslp_cfg;
    clk_cfg_t    want_cfg;
    clk_cfg_t    act_q;
    logic        skip;
    logic [2:0]  sel;
    logic [5:0]  div;
    logic        pll_pd;

    // Dividers
    logic [1:0]  int_pre_q;
    logic        int4_tick;
    logic        half_q;
    logic        pll_half_tick;
    logic        src_tick;
    logic [6:0]  sys_cnt_q;
    logic        sys_wrap;
    logic [4:0]  adc_cnt_q;
    logic        sys_en_q;
    logic        adc_en_q;
    logic [`N_PERIPH-1:0] periph_en_q;

    ////////////////////////////////////////////////////////////////////
    // Divisor from path, enable and code
    // Seven bits so that code 0x3f plus one still fits
    function automatic logic [6:0] divisor_of(
        input logic       use_pll,
        input logic       en,
        input logic [5:0] code
    );
        logic [6:0] n;
        n = {1'b0, code} + 7'h01;
        if (use_pll) begin
            divisor_of = n;
        end else if (!en) begin
            divisor_of = 7'h01;
        end else if (code <= 6'h01) begin
            divisor_of = 7'h02;
        end else begin
            divisor_of = n;
        end
    endfunction

    ////////////////////////////////////////////////////////////////////
    // APB decode; answers in the first access cycle
    // Status word: 2:0 source, 3 PLL in use, 4 deep sleep, 11:5 divisor
    assign setup  = apb_req_in.psel && !apb_req_in.penable;
    assign access = apb_req_in.psel && apb_req_in.penable;

    always_comb begin
        hit     = 1'b1;
        rdata_d = 32'h00000000;
        unique case (apb_req_in.paddr)
            `OFS_RUN_CFG:  rdata_d = run_cfg_q;
            `OFS_RUN_EXT:  rdata_d = run_ext_q;
            `OFS_DSLP_CFG: rdata_d = dslp_cfg_q;
            `OFS_GATE:     rdata_d = gate_q;
            `OFS_STATUS: begin
                rdata_d = {20'h00000, act_q.divisor,
                           deep_sleep_in, act_q.use_pll, act_q.src};
            end
            default:       hit = 1'b0;
        endcase
    end

    // Read data captured in setup so it comes from a flop
    // and stands unchanged through the access cycle.
    always_ff @(posedge mclk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            prdata_q <= 32'h00000000;
        end else if (setup) begin
            prdata_q <= rdata_d;
        end
    end

    // Zero wait states; unmapped addresses flag an error
    assign apb_rsp_out.pready  = 1'b1;
    assign apb_rsp_out.pslverr = access && !hit;
    assign apb_rsp_out.prdata  = prdata_q;

    ////////////////////////////////////////////////////////////////////
    // Register writes; reserved bits masked off
    always_ff @(posedge mclk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            run_cfg_q  <= `RST_RUN_CFG;
            run_ext_q  <= `RST_RUN_EXT;
            dslp_cfg_q <= `RST_DSLP_CFG;
            gate_q     <= `RST_GATE;
        end else if (access && apb_req_in.pwrite) begin
            unique case (apb_req_in.paddr)
                `OFS_RUN_CFG: begin
                    run_cfg_q <= apb_req_in.pwdata & `MASK_RUN_CFG;
                end
                `OFS_RUN_EXT: begin
                    run_ext_q <= apb_req_in.pwdata & `MASK_RUN_EXT;
                end
                `OFS_DSLP_CFG: begin
                    dslp_cfg_q <= apb_req_in.pwdata & `MASK_DSLP_CFG;
                end
                `OFS_GATE: begin
                    gate_q <= {{(32-`N_PERIPH){1'b0}},
                               apb_req_in.pwdata[`N_PERIPH-1:0]};
                end
                default: begin
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Field selection between the two run registers
    always_comb begin
        // each wide field replaces its narrow one
        if (run_ext_q[`POS_USE_EXT]) begin
            skip   = run_ext_q[`POS_SKIP];
            pll_pd = run_ext_q[`POS_PLL_PD];
            sel    = run_ext_q[`POS_OSC_SEL +: 3];
            div    = run_ext_q[`POS_DIV +: 6];
        end else begin
            skip   = run_cfg_q[`POS_SKIP];
            pll_pd = run_cfg_q[`POS_PLL_PD];
            sel    = {1'b0, run_cfg_q[`POS_OSC_SEL +: 2]};
            div    = {2'b00, run_cfg_q[`POS_DIV +: 4]};
        end
    end

    // Run-mode source and divisor
    always_comb begin
        // PLL only when not skipped and select is main
        run_cfg.use_pll = !skip && (sel == `SRC_MAIN);
        // real-time source needs skip and code 7
        if (!skip && sel == `SRC_RTC) begin
            run_cfg.src = `SRC_INT;
        end else begin
            run_cfg.src = sel;
        end
        run_cfg.divisor = divisor_of(run_cfg.use_pll,
                                     run_cfg_q[`POS_DIV_EN], div);
    end

    // Deep-sleep source and divider; PLL is not used there
    always_comb begin
        dslp_cfg.use_pll = 1'b0;
        dslp_cfg.src     = dslp_cfg_q[`POS_OSC_SEL +: 3];
        dslp_cfg.divisor = divisor_of(1'b0, 1'b1,
                                      dslp_cfg_q[`POS_DIV +: 6]);
    end

    assign want_cfg = deep_sleep_in ? dslp_cfg : run_cfg;

    ////////////////////////////////////////////////////////////////////
    // Internal oscillator prescaler, divide by four
    always_ff @(posedge mclk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            int_pre_q <= 2'h0;
        end else if (internal_osc_tick_in) begin
            int_pre_q <= int_pre_q + 2'h1;
        end
    end
    assign int4_tick = internal_osc_tick_in
                       && (int_pre_q == 2'(`INT_PRE_DIV - 1));

    always_ff @(posedge mclk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            half_q <= 1'b0;
        end else if (pll_vco_tick_in) begin
            half_q <= !half_q;
        end
    end
    // A powered-down PLL yields no ticks, so its path simply stalls
    assign pll_half_tick = pll_vco_tick_in && half_q && !pll_pd;

    ////////////////////////////////////////////////////////////////////
    // Source multiplexer on the active configuration
    always_comb begin
        if (act_q.use_pll) begin
            src_tick = pll_half_tick;
        end else begin
            unique case (act_q.src)
                `SRC_MAIN: src_tick = main_osc_tick_in;
                `SRC_INT:  src_tick = internal_osc_tick_in;
                `SRC_INT4: src_tick = int4_tick;
                `SRC_SLOW: src_tick = slow_osc_tick_in;
                `SRC_RTC:  src_tick = rtc_osc_tick_in;
                default:   src_tick = internal_osc_tick_in;
            endcase
        end
    end

    // Output period ends on this source tick
    // Greater-or-equal keeps a count above the divisor from running away
    assign sys_wrap = src_tick && (sys_cnt_q >= act_q.divisor - 7'h01);

    // System divider counter
    always_ff @(posedge mclk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            sys_cnt_q <= 7'h00;
        end else if (sys_wrap) begin
            sys_cnt_q <= 7'h00;
        end else if (src_tick) begin
            sys_cnt_q <= sys_cnt_q + 7'h01;
        end
    end

    // A source that stops ticking freezes the switch, so software keeps
    // the running source alive until the new one has taken over.
    // switch only at a period boundary
    always_ff @(posedge mclk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            act_q.use_pll <= 1'b0;
            act_q.src     <= `SRC_INT;
            act_q.divisor <= 7'h01;
        end else if (sys_wrap) begin
            act_q <= want_cfg;
        end
    end

    // System clock enable from a flop
    always_ff @(posedge mclk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            sys_en_q <= 1'b0;
        end else begin
            sys_en_q <= sys_wrap;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Raw VCO ticks are counted, so the ADC rate ignores the system
    // divider; it stops while the PLL is powered down.
    // fixed ADC divider from the VCO
    always_ff @(posedge mclk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            adc_cnt_q <= 5'h00;
            adc_en_q  <= 1'b0;
        end else begin
            adc_en_q <= 1'b0;
            if (pll_vco_tick_in && !pll_pd) begin
                if (adc_cnt_q == 5'(`ADC_DIV - 1)) begin
                    adc_cnt_q <= 5'h00;
                    adc_en_q  <= 1'b1;
                end else begin
                    adc_cnt_q <= adc_cnt_q + 5'h01;
                end
            end
        end
    end

    always_ff @(posedge mclk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            periph_en_q <= '0;
        end else begin
            periph_en_q <= {`N_PERIPH{sys_wrap}} & gate_q[`N_PERIPH-1:0];
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Outputs
    assign system_clock_en_out = sys_en_q;
    assign adc_clock_en_out    = adc_en_q;
    assign periph_clock_en_out = periph_en_q;
    // main oscillator off until software enables it
    assign main_osc_enable_out = !run_cfg_q[`POS_OSC_OFF];
    assign pll_power_on_out    = !pll_pd;
    assign crystal_select_out  = run_cfg_q[`POS_CRYSTAL_SELECT +: 5];

endmodule

// file: verif/clk_div_monitor.sv
// Port checks for the system clock source divider.
// Assumes one clock domain and the constants header on the path.
`timescale 1ns/1ps
`include "clock_divider_params.svh"
module clk_div_monitor (
    // Clock and reset
    input wire logic                        mclk_in,
    input wire logic                        rstn_in,
    // Register bus
    input wire clock_divider_pkg::apb_req_t apb_req_in,
    input wire clock_divider_pkg::apb_rsp_t apb_rsp_out,
    // Source ticks
    input wire logic                        internal_osc_tick_in,
    input wire logic                        main_osc_tick_in,
    input wire logic                        slow_osc_tick_in,
    input wire logic                        rtc_osc_tick_in,
    input wire logic                        pll_vco_tick_in,
    // Outputs watched
    input wire logic                        main_osc_enable_out,
    input wire logic                        pll_power_on_out,
    input wire logic                        system_clock_en_out,
    input wire logic                        adc_clock_en_out,
    input wire logic [`N_PERIPH-1:0]        periph_clock_en_out
);
    logic any_tick;
    logic acc;
    logic wr0;
    logic wr4;
    ////////////////////////////////////////////////////////////////////
    // Helpers: any source tick, completed writes to the two configs
    assign any_tick = internal_osc_tick_in | main_osc_tick_in |
                      slow_osc_tick_in | rtc_osc_tick_in | pll_vco_tick_in;
    assign acc = apb_req_in.psel & apb_req_in.penable;
    assign wr0 = acc & apb_req_in.pwrite & (apb_req_in.paddr == 8'h00);
    assign wr4 = acc & apb_req_in.pwrite & (apb_req_in.paddr == 8'h04);
    default clocking @(posedge mclk_in); endclocking
    default disable iff (!rstn_in);
    ////////////////////////////////////////////////////////////////////
    a_sys_after_tick:
    assert property (system_clock_en_out |-> $past(any_tick))
        else $error("system pulse without a source tick");
    a_gate_follows:
    assert property ((periph_clock_en_out & ~{8{system_clock_en_out}}) == 0)
        else $error("peripheral pulse outside system pulse");
    a_adc_after_vco:
    assert property (adc_clock_en_out |-> $past(pll_vco_tick_in))
        else $error("adc pulse without a vco tick");
    a_adc_spacing:
    assert property (adc_clock_en_out |=> !adc_clock_en_out [*8])
        else $error("adc pulses too close");
    a_main_osc_by_write:
    assert property ($changed(main_osc_enable_out) |-> $past(wr0))
        else $error("main oscillator enable moved without a write");
    a_pll_by_write:
    assert property ($changed(pll_power_on_out) |-> $past(wr0 | wr4))
        else $error("pll power moved without a write");
    a_err_unmapped:
    assert property (apb_rsp_out.pslverr == (acc &
        (apb_req_in.paddr[1:0] != 0 || apb_req_in.paddr > 8'h10)))
        else $error("slave error does not match the map");
    a_rdata_hold:
    assert property ($changed(apb_rsp_out.prdata) |->
        $past(apb_req_in.psel & !apb_req_in.penable))
        else $error("read data moved outside a setup cycle");
endmodule

// file: verif/osc_tick_model.sv
// Behavioural oscillators giving one-cycle ticks for each source.
// Assumes ticks are sampled on the rising edge of mclk_in.
`timescale 1ns/1ps
module osc_tick_model (
    // Clock and reset
    input  wire logic       mclk_in,
    input  wire logic       rstn_in,
    // Controls from the block
    input  wire logic       main_on_in,
    input  wire logic       pll_on_in,
    // Ticks: vco, rtc, slow, main, internal
    output      logic [4:0] tick_out
);
    // Periods in mclk cycles, internal first; the testbench expects these exact periods
    localparam int PER [5] = '{2, 3, 5, 3, 2};
    localparam int STAB = 20;
    int         cnt [5];
    int         stab_q;
    logic [4:0] run;
    ////////////////////////////////////////////////////////////////////
    // main oscillator settles before ticking
    always_ff @(posedge mclk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            stab_q <= 0;
        end else if (!main_on_in) begin
            stab_q <= 0;
        end else if (stab_q < STAB) begin
            stab_q <= stab_q + 1;
        end
    end
    assign run = {pll_on_in, 2'b11, stab_q >= STAB, 1'b1};
    // A stopped source drops its tick instead of holding it
    always_ff @(posedge mclk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            cnt <= '{default: 0};
            tick_out <= '0;
        end else begin
            for (int i = 0; i < 5; i++) begin
                cnt[i] <= (!run[i] || cnt[i] == PER[i] - 1) ? 0 : cnt[i] + 1;
                tick_out[i] <= run[i] && cnt[i] == PER[i] - 1;
            end
        end
    end
endmodule

// file: verif/system_clock_source_divider_tb.sv
// Testbench for the system clock source divider.
// Assumes the oscillator model and the monitor are compiled first.
`timescale 1ns/1ps
`include "clock_divider_params.svh"
module system_clock_source_divider_tb;
    import clock_divider_pkg::*;
    logic       mclk_in = 1'b0;
    logic       rstn_in = 1'b0;
    logic       deep_sleep_in = 1'b0;
    apb_req_t   apb_req_in = '0;
    apb_rsp_t   apb_rsp_out;
    wire        internal_osc_tick_in, main_osc_tick_in, slow_osc_tick_in;
    wire        rtc_osc_tick_in, pll_vco_tick_in;
    logic       main_osc_enable_out, pll_power_on_out;
    logic       system_clock_en_out, adc_clock_en_out;
    logic [4:0] crystal_select_out;
    logic [7:0] periph_clock_en_out;
    int         errors = 0;
    int         n_tests = 0;
    ////////////////////////////////////////////////////////////////////
    // 25 MHz clock
    always #20 mclk_in = ~mclk_in;
    osc_tick_model u_osc (.mclk_in, .rstn_in, .main_on_in(main_osc_enable_out),
        .pll_on_in(pll_power_on_out), .tick_out({pll_vco_tick_in,
        rtc_osc_tick_in, slow_osc_tick_in, main_osc_tick_in,
        internal_osc_tick_in}));
    system_clock_source_divider u_dut (.mclk_in, .rstn_in, .apb_req_in,
        .apb_rsp_out, .internal_osc_tick_in, .main_osc_tick_in,
        .slow_osc_tick_in, .rtc_osc_tick_in, .pll_vco_tick_in,
        .deep_sleep_in, .main_osc_enable_out, .pll_power_on_out,
        .crystal_select_out, .system_clock_en_out, .adc_clock_en_out,
        .periph_clock_en_out);
    ////////////////////////////////////////////////////////////////////
    // Config words; crystal code 0x15 and main oscillator kept on
    function automatic logic [31:0] rc(input logic [1:0] s, input logic sk,
        input logic pd, input logic de, input logic [3:0] d);
        rc = {5'h0, d, de, 8'h0, pd, 1'b0, sk, 5'h15, s, 4'h0};
    endfunction
    function automatic logic [31:0] re(input logic u, input logic sk,
        input logic [2:0] s, input logic [5:0] d);
        re = {u, 2'b0, d, 9'h0, 1'b0, 1'b0, sk, 4'h0, s, 4'h0};
    endfunction
    task automatic check(input logic [32:0] seen, input logic [32:0] exp);
        n_tests++;
        if (seen !== exp) begin
            errors++;
            $display("FAIL %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    // One APB transfer; returns {pslverr, prdata}
    task automatic apb(input logic w, input logic [7:0] a,
        input logic [31:0] d, output logic [32:0] r);
        @(posedge mclk_in);
        apb_req_in <= '{1'b1, 1'b0, w, a, d};
        @(posedge mclk_in);
        apb_req_in.penable <= 1'b1;
        // Wait states are up to the slave; only the watchdog ends a wait
        do begin
            @(posedge mclk_in);
        end while (apb_rsp_out.pready !== 1'b1);
        r = {apb_rsp_out.pslverr, apb_rsp_out.prdata};
        apb_req_in.psel <= 1'b0;
        apb_req_in.penable <= 1'b0;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [32:0] r;
        apb(1'b1, a, d, r);
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        logic [32:0] r;
        apb(1'b0, a, 32'h0, r);
        check(r, {1'b0, e});
    endtask
    // Period between third and fourth pulse, so a switch has settled
    task automatic meas(input int p, input logic adc);
        int n, c, t;
        n = 0;
        c = 0;
        t = 0;
        while (n < 4 && c < 3000) begin
            @(negedge mclk_in);
            c++;
            if ((adc ? adc_clock_en_out : system_clock_en_out) === 1'b1) begin
                n++;
                t = (n == 4) ? c - t : c;
            end
        end
        check(33'((n == 4) ? t : 0), 33'(p));
    endtask
    task automatic step(input logic [7:0] a, input logic [31:0] d, int p);
        wr(a, d);
        rd(a, d);
        meas(p, 1'b0);
    endtask
    task automatic tally_and_finish();
        $display("comparisons %0d mismatches %0d", n_tests, errors);
        if (errors == 0 && n_tests > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////
    // Watchdog far beyond the few thousand cycles the tests need
    initial begin
        repeat (40000) @(posedge mclk_in);
        errors++;
        tally_and_finish();
    end
    initial begin
        logic [32:0] r;
        repeat (2) @(posedge mclk_in);
        rstn_in <= 1'b1;
        rd(8'h00, `RST_RUN_CFG);
        rd(8'h04, `RST_RUN_EXT);
        rd(8'h08, 32'h0);
        rd(8'h10, 32'h21);
        check({32'h0, pll_power_on_out}, 33'h0);
        meas(2, 1'b0);
        apb(1'b1, 8'h14, 32'hffffffff, r);
        check({32'h0, r[32]}, 33'h1);
        apb(1'b0, 8'h14, 32'h0, r);
        check(r, {1'b1, 32'h0});
        $display("test reset and map done");
        step(8'h00, rc(2'h1, 1'b1, 1'b1, 1'b0, 4'hf), 2);
        check({28'h0, crystal_select_out}, 33'h15);
        check({32'h0, main_osc_enable_out}, 33'h1);
        step(8'h00, rc(2'h2, 1'b1, 1'b1, 1'b0, 4'hf), 8);
        step(8'h00, rc(2'h3, 1'b1, 1'b1, 1'b0, 4'hf), 5);
        step(8'h00, rc(2'h0, 1'b1, 1'b1, 1'b0, 4'hf), 3);
        step(8'h00, rc(2'h0, 1'b1, 1'b1, 1'b1, 4'h0), 6);
        step(8'h00, rc(2'h0, 1'b1, 1'b1, 1'b1, 4'h1), 6);
        step(8'h00, rc(2'h0, 1'b1, 1'b1, 1'b1, 4'h4), 15);
        step(8'h00, rc(2'h0, 1'b0, 1'b0, 1'b1, 4'h3), 16);
        check({32'h0, pll_power_on_out}, 33'h1);
        meas(50, 1'b1);
        $display("test run config done");
        step(8'h04, re(1'b1, 1'b1, 3'h7, 6'h3f), 192);
        step(8'h04, re(1'b1, 1'b0, 3'h7, 6'h03), 8);
        step(8'h04, re(1'b1, 1'b1, 3'h1, 6'h20), 66);
        step(8'h04, re(1'b0, 1'b1, 3'h1, 6'h20), 16);
        step(8'h00, rc(2'h1, 1'b1, 1'b0, 1'b0, 4'hf), 2);
        wr(8'h0c, 32'hffffffa5);
        rd(8'h0c, 32'h000000a5);
        repeat (20) begin
            @(negedge mclk_in);
            check(33'(periph_clock_en_out),
                  33'(system_clock_en_out ? 8'ha5 : 8'h00));
        end
        $display("test override and gates done");
        wr(8'h08, 32'h01000010);
        deep_sleep_in <= 1'b1;
        meas(6, 1'b0);
        rd(8'h10, 32'h00000071);
        deep_sleep_in <= 1'b0;
        meas(2, 1'b0);
        @(posedge mclk_in);
        rstn_in <= 1'b0;
        repeat (2) @(posedge mclk_in);
        rstn_in <= 1'b1;
        rd(8'h00, `RST_RUN_CFG);
        meas(2, 1'b0);
        $display("test sleep and second reset done");
        tally_and_finish();
    end
endmodule
bind system_clock_source_divider clk_div_monitor u_mon (.mclk_in, .rstn_in,
    .apb_req_in, .apb_rsp_out, .internal_osc_tick_in, .main_osc_tick_in,
    .slow_osc_tick_in, .rtc_osc_tick_in, .pll_vco_tick_in,
    .main_osc_enable_out, .pll_power_on_out, .system_clock_en_out,
    .adc_clock_en_out, .periph_clock_en_out);
